// [logic/sst_map.vh]
// register map, field positions, reset values and timing counts of the ramp converter timer
`ifndef SST_MAP_VH
`define SST_MAP_VH
// ************************************************************
// register byte offsets
// ************************************************************
`define SST_OFF_MODE     12'h000
`define SST_OFF_TRIM     12'h004
`define SST_OFF_SYNCWT   12'h008
`define SST_OFF_RES_ONE  12'h010
`define SST_OFF_RES_TWO  12'h014
`define SST_OFF_RES_THR  12'h018
`define SST_OFF_RES_AUX  12'h01c
`define SST_OFF_STATUS   12'h020
// ************************************************************
// mode control fields and register reset values
// ************************************************************
`define SST_MODE_SEL_LO  0
`define SST_MODE_SEL_HI  1
`define SST_MODE_RATE    7
`define SST_MODE_DBL     9
`define SST_MODE_RESET   10'h000
`define SST_TRIM_RESET   3'h0
`define SST_SYNCWT_RESET 8'h28
// ************************************************************
// timer and pulse constants
// ************************************************************
`define SST_TIMER_MAX    12'hfff
`define SST_NO_RESULT    12'h000
`define SST_CLK_MHZ      50
`define SST_MIN_SYNC_NS  50
`define SST_MIN_SYNC_CYC ((`SST_MIN_SYNC_NS * `SST_CLK_MHZ + 999) / 1000)
`endif

// [logic/sst_capture.v]
// one capture channel: latches the timer on the first comparator trip of a window
`default_nettype none
module sst_capture #(
   parameter W = 12
) (
   input  wire         mclk,
   input  wire         reset_n,
   input  wire         window_start,
   input  wire         window_end,
   input  wire         trip,
   input  wire [W-1:0] timer_value,
   output wire [W-1:0] result
);
   reg [W-1:0] result_reg;
   reg         seen_reg;
   reg         trip_meta_reg;
   reg         trip_sync_reg;
   reg         trip_last_reg;
   wire        trip_rise;

   assign trip_rise = trip_sync_reg & ~trip_last_reg;
   assign result    = result_reg;

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         trip_meta_reg <= 1'b0;
         trip_sync_reg <= 1'b0;
         trip_last_reg <= 1'b0;
         seen_reg      <= 1'b0;
         result_reg    <= {W{1'b0}};
      end else begin
         trip_meta_reg <= trip;
         trip_sync_reg <= trip_meta_reg;
         trip_last_reg <= trip_sync_reg;
         if (window_start) begin
            seen_reg <= 1'b0;
            // the closing window had no crossing, so its result reads zero
            if (window_end && !seen_reg) begin
               result_reg <= {W{1'b0}};                       // see R10
            end
         end else if (trip_rise && !seen_reg) begin
            seen_reg   <= 1'b1;
            result_reg <= timer_value;                        // see R7 R14
         end
      end
   end
endmodule // sst_capture
`default_nettype wire

// [logic/sst_adc_timer.v]
// control side of the four-channel single-slope converter with an apb register slave
// How it works
// R1: select bits 00,01,10 pick aux inputs zero..two, 11 the calibration reference.
// R2: four channels convert together against one shared ramp.
// R3: a 12-bit timer measures ramp start to crossing, stored per channel.
// R4: the sync pulse discharges the ramp and restarts the timer.
// R5: software sets the sync width long enough to fully discharge the ramp; here sync_width_reg drives nothing and the width comes from cycle_sync_pulse.
// R6: mode bit 7 clear counts at half core rate, set at core rate.
// R7: four capture registers latch the timer when their comparator trips.
// R8: max count is min of 4095 and usable period over tick time.
// R9: double update gives half-period windows, single update the full period.
// R10: a channel with no crossing in the window reads zero.
// R11: 3-bit ramp trim, writable, resets to zero, larger is more current.
// R12: software steps trim up from zero until reference reading drops below target.
// R13: current sense is sampled on the falling edge of the sync pulse.
// R14: captures hold their value until a trip in the next window, or until that window closes with no trip.
// R15: the timer stops at its maximum until the next sync pulse.
//
// The APB slave port and the register addresses were left to the implementer.
`default_nettype none
`include "sst_map.vh"
module sst_adc_timer (
   input  wire        mclk,
   input  wire        reset_n,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output wire        pslverr,
   output reg  [31:0] prdata,
   input  wire        cycle_sync_pulse,
   input  wire        trip_main_one,
   input  wire        trip_main_two,
   input  wire        trip_current,
   input  wire        trip_aux,
   output wire        ramp_discharge,
   output wire [1:0]  aux_select,
   output wire        aux_select_high,
   output wire        aux_select_low,
   output wire [2:0]  ramp_current_trim,
   output wire        sense_hold_strobe,
   output wire        sync_width_short
);
   // ************************************************************
   // registers
   // ************************************************************
   reg  [9:0]  mode_control_reg;
   reg  [2:0]  trim_reg;
   reg  [7:0]  sync_width_reg;
   reg         sync_meta_reg;
   reg         sync_sync_reg;
   reg         sync_last_reg;
   reg  [11:0] timer_reg;
   reg  [11:0] timer_next;
   reg         tick_div_reg;
   reg         half_reg;
   reg         strobe_reg;
   reg         discharge_reg;
   reg         started_reg;
   reg  [15:0] high_cnt_reg;
   reg         short_reg;
   wire        sync_rise;
   wire        sync_fall;
   wire        window_start;
   wire        window_end;
   wire        tick;
   wire        wr_en;
   wire [11:0] res_one;
   wire [11:0] res_two;
   wire [11:0] res_thr;
   wire [11:0] res_aux;
   wire        addr_ok;

   // ************************************************************
   // sync pulse edges
   // ************************************************************
   // the pulse comes from outside, so it passes two flops first
   assign sync_rise = sync_sync_reg & ~sync_last_reg;
   assign sync_fall = ~sync_sync_reg & sync_last_reg;

   // in double update mode every sync rise opens a window (half period);
   // in single update only every second one does (full period)
   assign window_start = sync_rise & (mode_control_reg[`SST_MODE_DBL] | ~half_reg); // see R9
   assign window_end   = window_start & started_reg;

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sync_meta_reg <= 1'b0;
         sync_sync_reg <= 1'b0;
         sync_last_reg <= 1'b0;
         half_reg      <= 1'b0;
         strobe_reg    <= 1'b0;
         started_reg   <= 1'b0;
         discharge_reg <= 1'b0;
      end else begin
         sync_meta_reg <= cycle_sync_pulse;
         sync_sync_reg <= sync_meta_reg;
         sync_last_reg <= sync_sync_reg;
         if (sync_rise) begin
            half_reg <= ~half_reg;
         end
         if (window_start) begin
            started_reg <= 1'b1;
         end
         strobe_reg    <= sync_fall;                          // see R13
         discharge_reg <= sync_sync_reg;                      // see R4
      end
   end

   // ************************************************************
   // sync width check, flags a pulse shorter than the least width
   // ************************************************************
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         high_cnt_reg <= 16'h0000;
         short_reg    <= 1'b0;
      end else if (sync_sync_reg) begin
         if (high_cnt_reg != 16'hffff) begin
            high_cnt_reg <= high_cnt_reg + 16'h0001;
         end
      end else begin
         high_cnt_reg <= 16'h0000;
         if (sync_fall) begin
            short_reg <= (high_cnt_reg < `SST_MIN_SYNC_CYC);   // see R5
         end
      end
   end

   // ************************************************************
   // conversion timer
   // ************************************************************
   // slow rate: one tick every second core clock
   assign tick = mode_control_reg[`SST_MODE_RATE] | tick_div_reg; // see R6

   always @* begin
      timer_next = timer_reg;
      if (sync_sync_reg) begin
         timer_next = 12'h000;                                // see R4
      end else if (tick && timer_reg != `SST_TIMER_MAX) begin
         timer_next = timer_reg + 12'h001;                    // see R3 R8 R15
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         timer_reg    <= 12'h000;
         tick_div_reg <= 1'b0;
      end else begin
         timer_reg    <= timer_next;
         tick_div_reg <= sync_sync_reg ? 1'b0 : ~tick_div_reg;
      end
   end

   // ************************************************************
   // capture channels, all sharing one ramp timer
   // ************************************************************
   sst_capture #(.W(12)) u_cap_one (                          // see R2
      .mclk         (mclk),
      .reset_n      (reset_n),
      .window_start (window_start),
      .window_end   (window_end),
      .trip         (trip_main_one),
      .timer_value  (timer_reg),
      .result       (res_one)
   );
   sst_capture #(.W(12)) u_cap_two (
      .mclk         (mclk),
      .reset_n      (reset_n),
      .window_start (window_start),
      .window_end   (window_end),
      .trip         (trip_main_two),
      .timer_value  (timer_reg),
      .result       (res_two)
   );
   sst_capture #(.W(12)) u_cap_thr (
      .mclk         (mclk),
      .reset_n      (reset_n),
      .window_start (window_start),
      .window_end   (window_end),
      .trip         (trip_current),
      .timer_value  (timer_reg),
      .result       (res_thr)
   );
   sst_capture #(.W(12)) u_cap_aux (
      .mclk         (mclk),
      .reset_n      (reset_n),
      .window_start (window_start),
      .window_end   (window_end),
      .trip         (trip_aux),
      .timer_value  (timer_reg),
      .result       (res_aux)
   );

   // ************************************************************
   // apb slave
   // ************************************************************
   // zero wait states; unmapped addresses answer with pslverr
   assign addr_ok = (paddr == `SST_OFF_MODE)    | (paddr == `SST_OFF_TRIM) |
                    (paddr == `SST_OFF_SYNCWT)  | (paddr == `SST_OFF_RES_ONE) |
                    (paddr == `SST_OFF_RES_TWO) | (paddr == `SST_OFF_RES_THR) |
                    (paddr == `SST_OFF_RES_AUX) | (paddr == `SST_OFF_STATUS);
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   assign wr_en   = psel & penable & pwrite;

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mode_control_reg <= `SST_MODE_RESET;
         trim_reg         <= `SST_TRIM_RESET;                 // see R11
         sync_width_reg   <= `SST_SYNCWT_RESET;
      end else if (wr_en) begin
         case (paddr)
            `SST_OFF_MODE: begin
               mode_control_reg <= pwdata[9:0];
            end
            `SST_OFF_TRIM: begin
               trim_reg <= pwdata[2:0];                       // see R11
            end
            `SST_OFF_SYNCWT: begin
               sync_width_reg <= pwdata[7:0];
            end
            default: begin
               mode_control_reg <= mode_control_reg;
            end
         endcase
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            `SST_OFF_MODE:    prdata <= {22'h000000, mode_control_reg};
            `SST_OFF_TRIM:    prdata <= {29'h00000000, trim_reg};
            `SST_OFF_SYNCWT:  prdata <= {24'h000000, sync_width_reg};
            `SST_OFF_RES_ONE: prdata <= {20'h00000, res_one};
            `SST_OFF_RES_TWO: prdata <= {20'h00000, res_two};
            `SST_OFF_RES_THR: prdata <= {20'h00000, res_thr};
            `SST_OFF_RES_AUX: prdata <= {20'h00000, res_aux};
            `SST_OFF_STATUS:  prdata <= {18'h00000, short_reg, half_reg, 12'h000} |
                                        {20'h00000, timer_reg};
            default:          prdata <= 32'h00000000;
         endcase
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign aux_select_high   = mode_control_reg[`SST_MODE_SEL_HI];       // see R1
   assign aux_select_low    = mode_control_reg[`SST_MODE_SEL_LO];       // see R1
   assign aux_select        = {aux_select_high, aux_select_low};        // see R1
   assign ramp_current_trim = trim_reg;
   assign sense_hold_strobe = strobe_reg;
   assign ramp_discharge    = discharge_reg;
   assign sync_width_short  = short_reg;
endmodule // sst_adc_timer
`default_nettype wire

// [test/sst_chk.sv]
// port checker for the ramp converter timer
`default_nettype none
`include "sst_map.vh"
module sst_chk (
   input wire logic        mclk,
   input wire logic        reset_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pslverr,
   input wire logic        cycle_sync_pulse,
   input wire logic        ramp_discharge,
   input wire logic [1:0]  aux_select,
   input wire logic        aux_select_high,
   input wire logic        aux_select_low,
   input wire logic [2:0]  ramp_current_trim,
   input wire logic        sense_hold_strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   // *****
   // relations at the ports
   // *****
   logic acc;
   logic wr_mode;
   logic wr_trim;
   assign acc = psel && penable;
   assign wr_mode = acc && pwrite && paddr == `SST_OFF_MODE;
   assign wr_trim = acc && pwrite && paddr == `SST_OFF_TRIM;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   // only aligned words are judged: odd byte addresses are never issued
   addr_decode_a: assert property (acc && paddr[1:0] == 2'h0 |-> pslverr == !(paddr inside
      {`SST_OFF_MODE, `SST_OFF_TRIM, `SST_OFF_SYNCWT, [`SST_OFF_RES_ONE:`SST_OFF_STATUS]}))
      else $error("pslverr wrong");
   sel_split_a: assert property (aux_select == {aux_select_high, aux_select_low})
      else $error("select bits differ");
   sel_write_a: assert property (wr_mode |=> aux_select == $past(pwdata[1:0]))
      else $error("select not written");
   trim_write_a: assert property (wr_trim |=> ramp_current_trim == $past(pwdata[2:0]))
      else $error("trim not written");
   trim_hold_a: assert property (!wr_trim |=> $stable(ramp_current_trim))
      else $error("trim moved");
   disch_rise_a: assert property ($rose(cycle_sync_pulse) |-> ##[2:4] ramp_discharge)
      else $error("no discharge");
   disch_fall_a: assert property ($fell(cycle_sync_pulse) |-> ##[2:4] !ramp_discharge)
      else $error("discharge stuck");
   hold_strobe_a: assert property ($fell(cycle_sync_pulse) |-> ##[1:5] sense_hold_strobe)
      else $error("no hold strobe");
   strobe_once_a: assert property (sense_hold_strobe |=> !sense_hold_strobe)
      else $error("strobe too long");
endmodule // sst_chk
bind sst_adc_timer sst_chk sst_chk_i (.mclk(mclk), .reset_n(reset_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
   .cycle_sync_pulse(cycle_sync_pulse), .ramp_discharge(ramp_discharge),
   .aux_select(aux_select), .aux_select_high(aux_select_high),
   .aux_select_low(aux_select_low), .ramp_current_trim(ramp_current_trim),
   .sense_hold_strobe(sense_hold_strobe));
`default_nettype wire

// [test/sst_far_side.sv]
// model of the sync pulse source and the four ramp comparators
`default_nettype none
module sst_far_side (
   input  wire logic       mclk,
   output var  logic       sync_pulse,
   output var  logic [3:0] trip
);
   timeunit 1ns;
   timeprecision 1ps;
   // *****
   // one conversion period
   // *****
   initial begin
      sync_pulse = 1'b0;
      trip = 4'h0;
   end
   // a delay of 0 means that the ramp never crosses that input
   task automatic period(input int width, input int len, input int dly [4]);
      @(posedge mclk);
      sync_pulse <= 1'b1;
      trip <= 4'h0;
      repeat (width) @(posedge mclk);
      sync_pulse <= 1'b0;
      for (int t = 1; t <= len; t++) begin
         @(posedge mclk);
         for (int c = 0; c < 4; c++) if (dly[c] == t) trip[c] <= 1'b1;
      end
   endtask
endmodule // sst_far_side
`default_nettype wire

// [test/tb_top.sv]
// self-checking bench of the ramp converter timer
`default_nettype none
`include "sst_map.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr, sync, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, r0;
   logic [3:0]  trip;
   logic [1:0]  aux_sel;
   logic [2:0]  trim;
   int          err_total, samples_checked, b;
   int          d [4];
   sst_adc_timer sst_adc_timer_i (.mclk(mclk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .cycle_sync_pulse(sync), .trip_main_one(trip[0]),
      .trip_main_two(trip[1]), .trip_current(trip[2]), .trip_aux(trip[3]),
      .ramp_discharge(), .aux_select(aux_sel), .aux_select_high(), .aux_select_low(),
      .ramp_current_trim(trim), .sense_hold_strobe(), .sync_width_short());
   sst_far_side sst_far_side_i (.mclk(mclk), .sync_pulse(sync), .trip(trip));
   // *****
   // bus, compare and report
   // *****
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_total++;
         summarize();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(what, q, exp);
   endtask
   // counts moved by the timer in k core cycles at the given rate
   function automatic logic [31:0] ticks(input int fast, input int k);
      return fast ? k : k / 2;
   endfunction
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   initial begin
      {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
      void'($urandom(32'h59a57ede));
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      rchk("mode", `SST_OFF_MODE, 32'h0);
      rchk("trim", `SST_OFF_TRIM, 32'h0);
      rchk("syncwt", `SST_OFF_SYNCWT, 32'h28);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `SST_OFF_MODE, i);
         @(negedge mclk);
         check("aux sel", aux_sel, i);
      end
      for (int i = 0; i < 6; i++) begin
         b = $urandom % 8;
         apb(1'b1, `SST_OFF_TRIM, b);
         rchk("trim", `SST_OFF_TRIM, b);
         check("trim pin", trim, b);
      end
      apb(1'b1, 12'h00c, 32'hffff);
      rchk("hole", 12'h00c, 32'h0);
      check("hole err", e, 1'b1);
      $display("test registers done");
      apb(1'b1, `SST_OFF_MODE, 32'h280);
      b = 20 + $urandom % 80;
      d = '{b, b + 7, b + 14, 0};
      sst_far_side_i.period(5, 300, d);
      rchk("first", `SST_OFF_RES_ONE, b);
      r0 = q;
      check("first nonzero", r0 === 32'h0, 1'b0);
      for (int c = 1; c < 3; c++) rchk("capture", `SST_OFF_RES_ONE + 4 * c, r0 + ticks(1, 7 * c));
      d = '{0, 0, 0, b + 21};
      sst_far_side_i.period(5, 300, d);
      for (int c = 0; c < 3; c++) rchk("held", `SST_OFF_RES_ONE + 4 * c, r0 + ticks(1, 7 * c));
      rchk("aux", `SST_OFF_RES_AUX, r0 + ticks(1, 21));
      d = '{0, 0, 0, 0};
      sst_far_side_i.period(5, 300, d);
      for (int c = 0; c < 3; c++) rchk("missed", `SST_OFF_RES_ONE + 4 * c, `SST_NO_RESULT);
      rchk("aux held", `SST_OFF_RES_AUX, r0 + ticks(1, 21));
      $display("test captures done");
      apb(1'b1, `SST_OFF_MODE, 32'h283);
      b = 0;
      apb(1'b1, `SST_OFF_TRIM, 32'h0);
      do begin
         d = '{0, 0, 0, 200 - 20 * b};
         sst_far_side_i.period(5, 300, d);
         rchk("cal", `SST_OFF_RES_AUX, 200 - 20 * b);
         r0 = q;
         if (r0 > 150) begin
            b++;
            apb(1'b1, `SST_OFF_TRIM, b);
         end
      end while (r0 > 150 && b < 8);
      check("cal trim", trim, 3'h3);
      $display("test calibration done");
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, `SST_OFF_MODE, m ? 32'h280 : 32'h200);
         sst_far_side_i.period(5, 10, d);
         apb(1'b0, `SST_OFF_STATUS, 32'h0);
         r0 = q;
         @(posedge mclk);
         apb(1'b0, `SST_OFF_STATUS, 32'h0);
         check("rate", (q - r0) & 32'hfff, ticks(m, 4));
      end
      sst_far_side_i.period(5, 4200, d);
      apb(1'b0, `SST_OFF_STATUS, 32'h0);
      check("saturate", q[11:0], `SST_TIMER_MAX);
      $display("test timer done");
      summarize();
   end
endmodule // tb_top
`default_nettype wire
